//--- rtl/iplc_codec.sv
// pulse link codec with port role logic and per-port symbol buffers
// ----------------------------------------
// Functional notes
// - port B is always a two-wire pulse port.
// - port A is pulse or four-wire SPI, chosen by mode select.
// - in SPI mode port A is slave, port B is master.
// - in pulse mode the port receiving the start becomes slave.
// - transmitter drives positive, negative or off; off idles at zero.
// - plus-one is positive half then equal negative half.
// - minus-one is negative half then equal positive half.
// - long halves are 150 ns, short halves 50 ns.
// - each symbol is two halves and ends at idle.
// - halves must beat the filter; inversion must fall inside the window.
// - SPI mode detects chip select edges and clock rises with data.
// - chip select rise sends long plus, fall sends long minus.
// - clock rise sends short plus for data 1, short minus for 0.
// - in pulse mode the slave port rebuilds chip select, data and clock from symbols.
// - slave replies short minus only for 0; absence reads as 1.
// - SPI uses clock polarity 1, phase 1; data sampled at rise.
// - mode select high gives pulse mode, low gives SPI.
// ----------------------------------------
`timescale 1ns/1ps
module iplc_codec
	import iplc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic port_a_mode_select_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	input wire iplc_line_type [1:0] line_sense_i,
	output iplc_line_type [1:0] line_drive_o,
	output logic [1:0] tx_ready_o,
	input wire logic read_mode_i,
	input wire logic read_bit_i,
	output logic int_cs_n_o,
	output logic int_sclk_o,
	output logic int_sdi_o,
	output logic slave_port_o,
	output logic mode_o
);

	// ----------------------------------------
	// mode strap and spi edge detection
	// ----------------------------------------
	logic mode_q;
	logic cs_prev_q;
	logic sck_prev_q;
	logic slave_q;
	logic int_cs_n_q;
	logic int_sclk_q;
	logic int_sdi_q;
	logic reply_q;
	logic sdo_q;
	logic sdo_oe_q;
	logic [1:0] rx_v;
	iplc_sym_type [1:0] rx_sym;
	logic [1:0] push_v;
	iplc_sym_type [1:0] push_sym;

	// strap is sampled every cycle after reset; reset itself loads spi mode
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			mode_q <= MODE_SPI;
		else
			mode_q <= port_a_mode_select_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b1;
		end
		else
		begin
			cs_prev_q <= chip_select_n_i;
			sck_prev_q <= serial_clock_i;
		end
	end

	wire spi_mode = (mode_q == MODE_SPI);
	wire cs_rise = spi_mode & ~cs_prev_q & chip_select_n_i;
	wire cs_fall = spi_mode & cs_prev_q & ~chip_select_n_i;
	wire sck_rise = spi_mode & ~sck_prev_q & serial_clock_i;
	wire sck_fall = spi_mode & sck_prev_q & ~serial_clock_i;
	wire spi_v = cs_rise | cs_fall | sck_rise;
	// a chip select edge outranks a clock edge in the same cycle
	wire cs_edge = cs_rise | cs_fall;
	iplc_sym_type spi_sym;
	assign spi_sym.long_sym = cs_edge;
	assign spi_sym.plus = cs_edge ? cs_rise : serial_data_in_i;

	// ----------------------------------------
	// port roles
	// ----------------------------------------
	wire long_minus_a = rx_v[PORT_A] & rx_sym[PORT_A].long_sym & ~rx_sym[PORT_A].plus;
	wire long_minus_b = rx_v[PORT_B] & rx_sym[PORT_B].long_sym & ~rx_sym[PORT_B].plus;
	wire start_v = ~spi_mode & int_cs_n_q & (long_minus_a | long_minus_b);
	wire start_port = long_minus_a ? PORT_A : PORT_B;
	wire sel_slave = spi_mode ? PORT_A : (start_v ? start_port : slave_q);
	wire master = ~sel_slave;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			slave_q <= PORT_A;
		else
			slave_q <= sel_slave;
	end

	// ----------------------------------------
	// slave side rebuild and reply
	// ----------------------------------------
	wire sl_v = ~spi_mode & rx_v[sel_slave];
	iplc_sym_type sl_sym;
	assign sl_sym = rx_sym[sel_slave];
	wire sl_short = sl_v & ~sl_sym.long_sym;
	// reply only for a zero bit; a one is sent as silence
	wire rp_v = sl_short & ~int_cs_n_q & read_mode_i & ~read_bit_i;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			int_cs_n_q <= 1'b1;
			int_sclk_q <= 1'b1;
			int_sdi_q <= 1'b0;
		end
		else if (spi_mode)
		begin
			int_cs_n_q <= chip_select_n_i;
			int_sclk_q <= serial_clock_i;
			int_sdi_q <= serial_data_in_i;
		end
		else
		begin
			if (sl_v & sl_sym.long_sym)
				int_cs_n_q <= sl_sym.plus;
			if (sl_short)
				int_sdi_q <= sl_sym.plus;
			// one low cycle, then the rising edge with data already stable
			int_sclk_q <= ~sl_short;
		end
	end

	// ----------------------------------------
	// spi data out from master port replies
	// ----------------------------------------
	wire b_short_minus = rx_v[PORT_B] & ~rx_sym[PORT_B].long_sym & ~rx_sym[PORT_B].plus;

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
			reply_q <= 1'b1;
		else if (spi_mode & b_short_minus)
			reply_q <= 1'b0;
		else if (sck_rise)
			reply_q <= 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			sdo_q <= 1'b1;
			sdo_oe_q <= 1'b0;
		end
		else if (~spi_mode | chip_select_n_i)
		begin
			sdo_q <= 1'b1;
			sdo_oe_q <= 1'b0;
		end
		else if (sck_fall)
		begin
			sdo_q <= reply_q;
			sdo_oe_q <= ~reply_q;
		end
	end

	// ----------------------------------------
	// push selection per port
	// ----------------------------------------
	wire fw_v = sl_v;
	wire mst_v = spi_v | fw_v;
	iplc_sym_type mst_sym;
	assign mst_sym = spi_v ? spi_sym : sl_sym;

	// ----------------------------------------
	// per-port buffer, transmitter, receiver
	// ----------------------------------------
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		wire is_master = (master == 1'(p));
		// port A is silent while it serves as the spi port
		wire port_on = (p == 1) | ~spi_mode;
		assign push_v[p] = port_on & (is_master ? mst_v : rp_v);
		assign push_sym[p] = is_master ? mst_sym : SYM_SHORT_MINUS;

		iplc_sym_type buf_q [2];
		logic head_q;
		logic [1:0] cnt_q;
		logic rdy_q;
		iplc_tx_state_type tx_q;
		iplc_sym_type cur_q;
		logic [CNT_W-1:0] tcnt_q;
		iplc_line_type drv_q;

		wire pop = (tx_q == TX_IDLE) & (cnt_q != BUF_EMPTY);
		wire push = push_v[p] & (cnt_q != BUF_FULL);
		wire wr_idx = head_q ^ cnt_q[0];
		wire [1:0] cnt_d = cnt_q + 2'(push) - 2'(pop);
		wire [CNT_W-1:0] half_last = cur_q.long_sym ? LONG_HALF_LAST : SHORT_HALF_LAST;
		wire half_done = (tcnt_q == half_last);
		iplc_sym_type head_sym;
		assign head_sym = buf_q[head_q];

		always_ff @(posedge clock_i)
		begin
			if (reset_i)
			begin
				head_q <= 1'b0;
				cnt_q <= BUF_EMPTY;
				rdy_q <= 1'b1;
			end
			else
			begin
				head_q <= head_q ^ pop;
				cnt_q <= cnt_d;
				rdy_q <= (cnt_d != BUF_FULL);
			end
		end

		always_ff @(posedge clock_i)
		begin
			if (push)
				buf_q[wr_idx] <= push_sym[p];
		end

		always_ff @(posedge clock_i)
		begin
			if (reset_i)
			begin
				tx_q <= TX_IDLE;
				cur_q <= SYM_SHORT_MINUS;
				tcnt_q <= '0;
				drv_q <= LINE_OFF;
			end
			else
			begin
				unique case (tx_q)
					TX_IDLE:
					begin
						tcnt_q <= '0;
						if (pop)
						begin
							tx_q <= TX_FIRST;
							cur_q <= head_sym;
							drv_q <= head_sym.plus ? LINE_POS : LINE_NEG;
						end
					end
					TX_FIRST:
					begin
						tcnt_q <= half_done ? '0 : tcnt_q + CNT_ONE;
						if (half_done)
						begin
							tx_q <= TX_SECOND;
							drv_q <= cur_q.plus ? LINE_NEG : LINE_POS;
						end
					end
					TX_SECOND:
					begin
						tcnt_q <= half_done ? '0 : tcnt_q + CNT_ONE;
						if (half_done)
						begin
							tx_q <= TX_IDLE;
							drv_q <= LINE_OFF;
						end
					end
				endcase
			end
		end

		assign line_drive_o[p] = drv_q;
		assign tx_ready_o[p] = rdy_q;

		iplc_rx_state_type rx_q;
		logic pol_q;
		logic len_long_q;
		logic [CNT_W-1:0] rcnt_q;
		logic sym_v_q;
		iplc_sym_type sym_q;

		wire pos_only = line_sense_i[p].plus_line & ~line_sense_i[p].minus_line;
		wire neg_only = line_sense_i[p].minus_line & ~line_sense_i[p].plus_line;
		wire same_lvl = pol_q ? pos_only : neg_only;
		wire opp_lvl = pol_q ? neg_only : pos_only;
		wire [CNT_W-1:0] rcnt_inc = (rcnt_q == CNT_MAX) ? rcnt_q : rcnt_q + CNT_ONE;

		always_ff @(posedge clock_i)
		begin
			if (reset_i)
			begin
				rx_q <= RX_IDLE;
				pol_q <= 1'b0;
				len_long_q <= 1'b0;
				rcnt_q <= '0;
				sym_v_q <= 1'b0;
				sym_q <= SYM_SHORT_MINUS;
			end
			else
			begin
				sym_v_q <= 1'b0;
				unique case (rx_q)
					RX_IDLE:
					begin
						rcnt_q <= CNT_ONE;
						if (pos_only | neg_only)
						begin
							rx_q <= RX_FIRST;
							pol_q <= pos_only;
						end
					end
					RX_FIRST:
					begin
						if (same_lvl)
							rcnt_q <= rcnt_inc;
						else if (rcnt_q > FILT_CNT)
						begin
							len_long_q <= (rcnt_q >= LONG_MIN_CNT);
							rcnt_q <= CNT_ONE;
							rx_q <= opp_lvl ? RX_SECOND : RX_GAP;
						end
						else
							rx_q <= RX_IDLE;
					end
					RX_GAP:
					begin
						if (opp_lvl)
						begin
							rcnt_q <= CNT_ONE;
							rx_q <= RX_SECOND;
						end
						else if (same_lvl | (rcnt_q >= WNDW_CNT))
							rx_q <= RX_IDLE;
						else
							rcnt_q <= rcnt_inc;
					end
					RX_SECOND:
					begin
						if (opp_lvl)
							rcnt_q <= rcnt_inc;
						else
						begin
							rx_q <= RX_IDLE;
							sym_v_q <= (rcnt_q > FILT_CNT);
							sym_q <= '{long_sym: len_long_q, plus: pol_q};
						end
					end
				endcase
			end
		end

		assign rx_v[p] = sym_v_q;
		assign rx_sym[p] = sym_q;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign serial_data_out_o = sdo_q;
	assign serial_data_out_oe_o = sdo_oe_q;
	assign int_cs_n_o = int_cs_n_q;
	assign int_sclk_o = int_sclk_q;
	assign int_sdi_o = int_sdi_q;
	assign slave_port_o = slave_q;
	assign mode_o = mode_q;

endmodule

//--- rtl/iplc_pkg.sv
// shared constants and types for the isolated pulse link codec
package iplc_pkg;

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int LONG_HALF_NS = 150;
	localparam int SHORT_HALF_NS = 50;
	localparam int FILT_NS = 20;
	localparam int WNDW_NS = 40;
	localparam int LONG_MIN_NS = 100;

	localparam int LONG_HALF_CYC = (LONG_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int SHORT_HALF_CYC = (SHORT_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int WNDW_CYC = (WNDW_NS * CLK_MHZ) / 1000;
	localparam int LONG_MIN_CYC = (LONG_MIN_NS * CLK_MHZ + 999) / 1000;

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] LONG_HALF_LAST = CNT_W'(LONG_HALF_CYC - 1);
	localparam logic [CNT_W-1:0] SHORT_HALF_LAST = CNT_W'(SHORT_HALF_CYC - 1);
	localparam logic [CNT_W-1:0] FILT_CNT = CNT_W'(FILT_CYC);
	localparam logic [CNT_W-1:0] WNDW_CNT = CNT_W'(WNDW_CYC);
	localparam logic [CNT_W-1:0] LONG_MIN_CNT = CNT_W'(LONG_MIN_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

	// ----------------------------------------
	// ports, modes, buffer
	// ----------------------------------------
	localparam logic PORT_A = 1'b0;
	localparam logic PORT_B = 1'b1;
	localparam logic MODE_SPI = 1'b0;
	localparam logic MODE_PULSE = 1'b1;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam logic [1:0] BUF_EMPTY = 2'h0;

	typedef struct packed {
		logic long_sym;
		logic plus;
	} iplc_sym_type;

	typedef struct packed {
		logic plus_line;
		logic minus_line;
	} iplc_line_type;

	localparam iplc_sym_type SYM_SHORT_MINUS = 2'h0;
	localparam iplc_line_type LINE_OFF = 2'h0;
	localparam iplc_line_type LINE_POS = 2'h2;
	localparam iplc_line_type LINE_NEG = 2'h1;

	typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} iplc_tx_state_type;
	typedef enum logic [1:0] {RX_IDLE, RX_FIRST, RX_GAP, RX_SECOND} iplc_rx_state_type;

endpackage

//--- tb/iplc_codec_props.sv
// assertions for the pulse link codec
`timescale 1ns/1ps
module iplc_codec_props
	import iplc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_in_i,
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe_o,
	input wire iplc_line_type [1:0] line_drive_o,
	input wire logic int_cs_n_o,
	input wire logic slave_port_o,
	input wire logic mode_o
);
	// ----
	// helpers
	// ----
	iplc_line_type prev_q;
	logic [7:0] run_q;
	logic second_q;
	logic cs_q;
	logic sck_q;
	logic ev_q;
	wire iplc_line_type ld = line_drive_o[1];
	wire edge_w = prev_q != LINE_OFF && ld != prev_q;
	wire ev_w = chip_select_n_i != cs_q || (serial_clock_i && !sck_q);
	// idle only when no event is still on its way into the buffer
	wire idle_w = ld == LINE_OFF && prev_q == LINE_OFF && !ev_q;
	always_ff @(posedge clock_i)
	begin
		prev_q <= reset_i ? LINE_OFF : ld;
		run_q <= (ld == prev_q) ? run_q + 8'h01 : 8'h01;
		second_q <= (ld == LINE_OFF) ? 1'b0 : (edge_w ? 1'b1 : second_q);
		cs_q <= chip_select_n_i;
		sck_q <= serial_clock_i;
		ev_q <= ev_w;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	port_a_quiet_a: assert property (mode_o == MODE_SPI |-> line_drive_o[0] == LINE_OFF)
		else $error("port A drove in spi mode");
	cs_edge_sym_a: assert property (mode_o == MODE_SPI && chip_select_n_i != cs_q && idle_w
		|-> ##2 ld == (chip_select_n_i ? LINE_POS : LINE_NEG)) else $error("cs symbol wrong");
	clk_bit_sym_a: assert property (mode_o == MODE_SPI && serial_clock_i && !sck_q && !chip_select_n_i
		&& !cs_q && idle_w |-> ##2 ld == (serial_data_in_i ? LINE_POS : LINE_NEG)) else $error("bit symbol wrong");
	half_width_a: assert property (edge_w |-> run_q == 8'(LONG_HALF_CYC) || run_q == 8'(SHORT_HALF_CYC))
		else $error("half width wrong");
	half_invert_a: assert property (edge_w && !second_q |-> ld == (prev_q ^ 2'h3))
		else $error("second half not inverted");
	sym_end_a: assert property (edge_w && second_q |-> ld == LINE_OFF)
		else $error("symbol not ended at idle");
	sdo_release_a: assert property (chip_select_n_i && cs_q && $past(cs_q)
		|-> !serial_data_out_oe_o && serial_data_out_o) else $error("data out not released");
	role_hold_a: assert property (!int_cs_n_o && $past(!int_cs_n_o) |-> $stable(slave_port_o))
		else $error("role changed while active");
	cover property (edge_w && second_q);
	cover property ($rose(slave_port_o));
	cover property (serial_data_out_oe_o);
endmodule
bind iplc_codec iplc_codec_props props (.clock_i, .reset_i, .chip_select_n_i, .serial_clock_i, .serial_data_in_i,
	.serial_data_out_o, .serial_data_out_oe_o, .line_drive_o, .int_cs_n_o, .slave_port_o, .mode_o);

//--- tb/iplc_codec_tb.sv
// self-checking bench for the pulse link codec
`timescale 1ns/1ps
module iplc_codec_tb
	import iplc_pkg::*;
;
	// ----
	// stimulus and monitor
	// ----
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic mode_sel = 1'b0;
	logic cs_n = 1'b1;
	logic sck = 1'b1;
	logic serial_data_in = 1'b0;
	logic [1:0] go = 2'h0;
	logic rd_md = 1'b0;
	logic rd_bit = 1'b1;
	iplc_sym_type sy = SYM_SHORT_MINUS;
	iplc_line_type la;
	iplc_line_type lb;
	iplc_line_type [1:0] drv;
	logic [1:0] rdy;
	logic serial_data_out, oe, ics, isck, isdi, slv, md;
	int n_mismatch = 0;
	int checked = 0;
	int mon = 1;
	iplc_line_type pl = LINE_OFF;
	logic [7:0] rn = 8'h00;
	logic [9:0] runs[$];
	initial forever #2.5 clock_i = ~clock_i;
	iplc_codec DUT (.clock_i, .reset_i, .port_a_mode_select_i(mode_sel), .chip_select_n_i(cs_n),
		.serial_clock_i(sck), .serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe),
		.line_sense_i({lb, la}), .line_drive_o(drv), .tx_ready_o(rdy), .read_mode_i(rd_md), .read_bit_i(rd_bit),
		.int_cs_n_o(ics), .int_sclk_o(isck), .int_sdi_o(isdi), .slave_port_o(slv), .mode_o(md));
	iplc_far_end far_a (.clock_i, .go_i(go[0]), .sym_i(sy), .line_o(la));
	iplc_far_end far_b (.clock_i, .go_i(go[1]), .sym_i(sy), .line_o(lb));
	// each finished positive or negative run on the watched port is logged as {level, length}; off runs are not logged
	always @(posedge clock_i)
	begin
		if (drv[mon] != pl && pl != LINE_OFF)
			runs.push_back({pl, rn});
		rn = (drv[mon] == pl) ? rn + 8'h01 : 8'h01;
		pl = drv[mon];
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic sym(input iplc_line_type f, input int h);
		int k;
		for (k = 0; k < 400 && runs.size() < 2; k++)
			@(negedge clock_i);
		if (runs.size() < 2)
		begin
			n_mismatch++;
			report_and_stop();
		end
		chk(runs.pop_front(), {f, 8'(h)});
		chk(runs.pop_front(), {f ^ 2'h3, 8'(h)});
	endtask
	task automatic pin(input logic c, input logic k, input logic d, input int w);
		@(negedge clock_i);
		cs_n = c;
		sck = k;
		serial_data_in = d;
		repeat (w) @(negedge clock_i);
	endtask
	task automatic send(input int p, input logic lng, input logic pls);
		@(negedge clock_i);
		go[p] = 1'b1;
		sy = '{lng, pls};
		@(negedge clock_i);
		go = 2'h0;
		repeat (2 * (lng ? LONG_HALF_CYC : SHORT_HALF_CYC) + 6) @(negedge clock_i);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		chk({drv, rdy, ics, isck, serial_data_out, oe, slv, md}, 12'h0F8);
	endtask
	task automatic t_spi();
		pin(1'b0, 1'b1, 1'b1, 2);
		pin(1'b0, 1'b0, 1'b1, 1);
		pin(1'b0, 1'b1, 1'b1, 1);
		pin(1'b0, 1'b0, 1'b0, 1);
		pin(1'b0, 1'b1, 1'b0, 1);
		pin(1'b0, 1'b0, 1'b1, 1);
		pin(1'b0, 1'b1, 1'b1, 1);
		chk(rdy[1], 1'b0);
		sym(LINE_NEG, LONG_HALF_CYC);
		sym(LINE_POS, SHORT_HALF_CYC);
		sym(LINE_NEG, SHORT_HALF_CYC);
		pin(1'b1, 1'b1, 1'b1, 40);
		chk(rdy, 2'h3);
		sym(LINE_POS, LONG_HALF_CYC);
		chk(12'(runs.size()), 12'h000);
	endtask
	task automatic t_reply();
		pin(1'b0, 1'b1, 1'b0, 70);
		pin(1'b0, 1'b0, 1'b0, 1);
		pin(1'b0, 1'b1, 1'b0, 25);
		send(1, 1'b0, 1'b0);
		pin(1'b0, 1'b0, 1'b0, 4);
		chk({serial_data_out, oe}, 2'h1);
		pin(1'b0, 1'b1, 1'b0, 30);
		pin(1'b0, 1'b0, 1'b0, 4);
		chk({serial_data_out, oe}, 2'h2);
		pin(1'b1, 1'b1, 1'b0, 70);
		chk({serial_data_out, oe}, 2'h2);
		runs.delete();
	endtask
	task automatic t_pulse();
		mode_sel = 1'b1;
		repeat (3) @(negedge clock_i);
		send(0, 1'b1, 1'b0);
		chk({md, slv, ics}, 3'h4);
		send(0, 1'b0, 1'b1);
		chk(isdi, 1'b1);
		send(0, 1'b1, 1'b1);
		chk(ics, 1'b1);
		sym(LINE_NEG, LONG_HALF_CYC);
		sym(LINE_POS, SHORT_HALF_CYC);
		sym(LINE_POS, LONG_HALF_CYC);
		mon = 0;
		send(1, 1'b1, 1'b0);
		chk({slv, ics}, 2'h2);
		// a zero read bit makes the slave answer with a short minus on its own line
		rd_md = 1'b1;
		rd_bit = 1'b0;
		send(1, 1'b0, 1'b0);
		chk(drv[1], LINE_NEG);
		rd_md = 1'b0;
		rd_bit = 1'b1;
		chk(isdi, 1'b0);
		send(1, 1'b1, 1'b1);
		sym(LINE_NEG, LONG_HALF_CYC);
		sym(LINE_NEG, SHORT_HALF_CYC);
		sym(LINE_POS, LONG_HALF_CYC);
	endtask
	initial
	begin
		repeat (12) @(negedge clock_i);
		reset_i = 1'b0;
		@(negedge clock_i);
		t_reset();
		t_spi();
		t_reply();
		t_pulse();
		report_and_stop();
	end
endmodule

//--- tb/iplc_far_end.sv
// far-end pulse transmitter model
`timescale 1ns/1ps
module iplc_far_end
	import iplc_pkg::*;
(
	input wire logic clock_i,
	input wire logic go_i,
	input wire iplc_sym_type sym_i,
	output iplc_line_type line_o
);
	// ----
	// symbol shaper
	// ----
	int n = 0;
	int h = 1;
	iplc_line_type f = LINE_OFF;
	initial line_o = LINE_OFF;
	// halves far above the filter, no gap at inversion, so the window always holds
	always @(posedge clock_i)
	begin
		if (n == 0 && go_i)
		begin
			h = sym_i.long_sym ? LONG_HALF_CYC : SHORT_HALF_CYC;
			f = sym_i.plus ? LINE_POS : LINE_NEG;
			n = 2 * h;
		end
		line_o <= (n == 0) ? LINE_OFF : ((n > h) ? f : f ^ 2'h3);
		if (n != 0)
			n = n - 1;
	end
endmodule
